// *** src/csd_consts.vh ***
// Constants for the configuration store and stepper drive block.
// Assumes a single 20 MHz clock; included by bare name from src/.
`ifndef CSD_CONSTS_VH
`define CSD_CONSTS_VH

// Clock rate in MHz, used to turn times into cycle counts.
`define CSD_CLK_MHZ        20
// Pulse widths in microseconds: 31.25 ms and 156.25 ms.
`define CSD_STEP_SHORT_US  31250
`define CSD_STEP_LONG_US   156250
// Cycle counts of those widths at 20 MHz, sized to the one-shot counters.
`define CSD_STEP_SHORT_CYC 22'h098968
`define CSD_STEP_LONG_CYC  22'h2FAF08
// Width of the one-shot counters.
`define CSD_MONO_W         22

// Configuration bit map addresses (6-bit).
`define CSD_ADDR_TEST_LOCK 6'h00
`define CSD_ADDR_CLK_RANGE 6'h01
`define CSD_ADDR_IND_DIV   6'h03
`define CSD_ADDR_SENSOR    6'h05
`define CSD_ADDR_MOTOR_DIV 6'h0E
// Number of configuration bit cells.
`define CSD_CFG_DEPTH      64

// Command byte fields.
`define CSD_CMD_VALUE_BIT  7
`define CSD_CMD_PERM_BIT   6
`define CSD_CMD_ADDR_MSB   5

// Pulse divisors for the scale bit low; the high scale multiplies by ten.
`define CSD_DIV_0          12'h040
`define CSD_DIV_1          12'h080
`define CSD_DIV_2          12'h020
`define CSD_DIV_3          12'h100
`define CSD_DIV_SCALE      12'h00A

// Sensor kind codes and gain values.
`define CSD_SENS_COIL      2'h0
`define CSD_SENS_CT        2'h1
`define CSD_SENS_SHUNT     2'h2
`define CSD_GAIN_8         6'h08
`define CSD_GAIN_16        6'h10
`define CSD_GAIN_24        6'h18
`define CSD_GAIN_32        6'h20

`endif

// *** src/csd_cfg_mem.v ***
// Configuration cell array: volatile shadow latches beside write-once fuses.
// Assumes writes come from the command logic on the same clock.
`timescale 1ns/1ps
`include "csd_consts.vh"

module csd_cfg_mem #(
  parameter ADDR_W = 6,
  parameter DEPTH  = `CSD_CFG_DEPTH
) (
  input  wire              i_clock,      // System clock.
  input  wire              i_rst_b,      // Synchronised reset, active low.
  input  wire              i_fuse_blank_b, // Blank fuse state, active low.
  input  wire              i_shadow_we,  // Shadow write strobe.
  input  wire              i_fuse_we,    // Fuse program strobe.
  input  wire [ADDR_W-1:0] i_addr,       // Bit address.
  input  wire              i_data,       // Value to store.
  input  wire              i_read_shadow, // Read source select.
  output reg  [DEPTH-1:0]  o_cfg_word,   // Selected configuration word.
  output wire              o_fuse_lock   // Test lock fuse state.
);

  reg [DEPTH-1:0] shadow_reg;            // Volatile copy.
  reg [DEPTH-1:0] fuse_reg;              // Nonvolatile copy.

  // Shadow latches are cleared by every reset and may be rewritten freely.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shadow_reg <= {DEPTH{1'b0}};
    end else if (i_shadow_we) begin
      shadow_reg[i_addr] <= i_data;
    end
  end

  // Fuses survive reset; only the blank state clears them, since that models
  // a fresh part. A fuse can only be blown, never restored.
  always @(posedge i_clock or negedge i_fuse_blank_b) begin
    if (!i_fuse_blank_b) begin
      fuse_reg <= {DEPTH{1'b0}};
    end else if (i_fuse_we && i_data) begin
      fuse_reg[i_addr] <= 1'b1;
    end
  end

  // Registered read of the chosen source.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cfg_word <= {DEPTH{1'b0}};
    end else begin
      o_cfg_word <= i_read_shadow ? shadow_reg : fuse_reg;
    end
  end

  // The lock follows the fuse itself, so a shadow copy cannot fake it.
  assign o_fuse_lock = fuse_reg[`CSD_ADDR_TEST_LOCK];

endmodule

// *** src/csd_top.v ***
// Configuration store and stepper motor drive, top level.
// Assumes one 20 MHz clock; energy, sign and no-load inputs are same-clock.
`timescale 1ns/1ps
`include "csd_consts.vh"

module csd_top #(
  parameter [`CSD_MONO_W-1:0] STEP_SHORT_CYC = `CSD_STEP_SHORT_CYC,
  parameter [`CSD_MONO_W-1:0] STEP_LONG_CYC  = `CSD_STEP_LONG_CYC
) (
  input  wire       i_clock,               // System clock, 20 MHz.
  input  wire       i_rst_b,               // Power-on reset, active low.
  input  wire       i_fuse_blank_b,        // Blank fuse state, active low.
  input  wire       i_cmd_valid,           // Command byte strobe.
  input  wire [7:0] i_cmd_byte,            // Command byte.
  input  wire       i_read_shadow,         // Read source select.
  input  wire       i_active_energy_pulse, // Energy pulse train.
  input  wire       i_energy_negative,     // Energy sign.
  input  wire       i_no_load,             // No-load detected.
  input  wire       i_voltage_scale_sel,   // Voltage scale select.
  input  wire       i_extra_gain_en,       // Extra gain enable.
  input  wire       i_dual_channel,        // Two current channels present.
  output reg        o_motor_out_pos,       // Motor output, positive pin.
  output reg        o_motor_out_neg,       // Motor output, negative pin.
  output reg        o_indicator,           // Indicator pin.
  output reg        o_cmd_done,            // Command accepted pulse.
  output reg        o_cmd_reject,          // Command refused pulse.
  output reg        o_test_lock,           // Permanent lock state.
  output reg        o_test_enable,         // Test mode permitted.
  output reg        o_clock_range_sel,     // Clock range select.
  output reg  [1:0] o_sensor_type_sel,     // Sensor type field.
  output reg  [1:0] o_primary_sensor,      // Primary sensor kind.
  output reg  [5:0] o_primary_gain,        // Primary channel gain.
  output reg  [1:0] o_secondary_sensor,    // Secondary sensor kind.
  output reg  [5:0] o_secondary_gain,      // Secondary channel gain.
  output reg  [1:0] o_motor_divide_code    // Motor divide field.
);

  // Shorthand for the one-shot counter width.
  localparam MW = `CSD_MONO_W;

  // Divisor for a scale bit and a two-bit code; shared by motor and indicator.
  // Kept in one place so both dividers agree on the table.
  function [11:0] csd_divisor;
    input       scale;
    input [1:0] code;
    reg   [11:0] base;
    begin
      case (code)
        2'h0:    base = `CSD_DIV_0;
        2'h1:    base = `CSD_DIV_1;
        2'h2:    base = `CSD_DIV_2;
        default: base = `CSD_DIV_3;
      endcase
      // The high scale is ten times the low one; 2560 still fits 12 bits.
      csd_divisor = scale ? base * `CSD_DIV_SCALE : base;
    end
  endfunction

  // Reset release synchroniser: asynchronous assert, two-flop release.
  // Release is delayed so every flop leaves reset on one edge.
  reg rst_meta_reg;                        // First stage.
  reg rst_sync_reg;                        // Stage used by the design.

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Only the second stage fans out.
  wire rst_b = rst_sync_reg;               // Internal reset, active low.

  // Command decode and memory write strobes.
  reg       shadow_we_reg;                 // Shadow write strobe.
  reg       fuse_we_reg;                   // Fuse write strobe.
  reg [5:0] wr_addr_reg;                   // Write address.
  reg       wr_data_reg;                   // Write value.
  wire      fuse_lock;                     // Lock fuse state.
  wire [`CSD_CFG_DEPTH-1:0] cfg_word;      // Selected configuration.

  // Once locked the shadows can no longer be chosen.
  // The lock is read from the fuse, not the selected word.
  wire read_shadow = i_read_shadow & ~fuse_lock;

  // Each accepted byte writes one bit; a locked part refuses all of them.
  // Strobes last one cycle, so back-to-back bytes land in order.
  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      shadow_we_reg <= 1'b0;
      fuse_we_reg   <= 1'b0;
      wr_addr_reg   <= 6'h00;
      wr_data_reg   <= 1'b0;
      o_cmd_done    <= 1'b0;
      o_cmd_reject  <= 1'b0;
    end else begin
      shadow_we_reg <= 1'b0;
      fuse_we_reg   <= 1'b0;
      o_cmd_done    <= 1'b0;
      o_cmd_reject  <= 1'b0;
      if (i_cmd_valid) begin
        if (fuse_lock) begin
          // Locked: nothing is stored, the refusal is only flagged.
          o_cmd_reject <= 1'b1;
        end else begin
          // One byte carries address, value and destination.
          wr_addr_reg   <= i_cmd_byte[`CSD_CMD_ADDR_MSB:0];
          wr_data_reg   <= i_cmd_byte[`CSD_CMD_VALUE_BIT];
          shadow_we_reg <= ~i_cmd_byte[`CSD_CMD_PERM_BIT];
          fuse_we_reg   <= i_cmd_byte[`CSD_CMD_PERM_BIT];
          o_cmd_done    <= 1'b1;
        end
      end
    end
  end

  // Cell array with registered read of the selected source.
  // Its read register adds one cycle before the fields change.
  csd_cfg_mem #(
    .ADDR_W (6),
    .DEPTH  (`CSD_CFG_DEPTH)
  ) u_cfg_mem (
    .i_clock        (i_clock),
    .i_rst_b        (rst_b),
    .i_fuse_blank_b (i_fuse_blank_b),
    .i_shadow_we    (shadow_we_reg),
    .i_fuse_we      (fuse_we_reg),
    .i_addr         (wr_addr_reg),
    .i_data         (wr_data_reg),
    .i_read_shadow  (read_shadow),
    .o_cfg_word     (cfg_word),
    .o_fuse_lock    (fuse_lock)
  );

  // Fields picked out of the selected configuration word.
  // Addresses come from the constants header.
  wire       cfg_test  = cfg_word[`CSD_ADDR_TEST_LOCK];
  wire       cfg_clk   = cfg_word[`CSD_ADDR_CLK_RANGE];
  wire       cfg_ind   = cfg_word[`CSD_ADDR_IND_DIV];
  // Lower address is the low bit of each two-bit field.
  wire [1:0] cfg_sens  = cfg_word[`CSD_ADDR_SENSOR +: 2];
  wire [1:0] cfg_motor = cfg_word[`CSD_ADDR_MOTOR_DIV +: 2];

  // Sensor and gain decode for both channels.
  // Defaults first, so no code can infer a latch.
  reg [1:0] pri_sens;                      // Primary kind.
  reg [5:0] pri_gain;                      // Primary gain.
  reg [1:0] sec_sens;                      // Secondary kind.
  reg [5:0] sec_gain;                      // Secondary gain.

  always @* begin
    pri_sens = `CSD_SENS_COIL;
    pri_gain = `CSD_GAIN_8;
    case (cfg_sens)
      2'h0: begin
        pri_sens = `CSD_SENS_COIL;
        pri_gain = i_extra_gain_en ? `CSD_GAIN_16 : `CSD_GAIN_8;
      end
      2'h1: begin
        pri_sens = `CSD_SENS_COIL;
        pri_gain = i_extra_gain_en ? `CSD_GAIN_32 : `CSD_GAIN_24;
      end
      2'h2: begin
        pri_sens = `CSD_SENS_CT;
        pri_gain = `CSD_GAIN_8;
      end
      default: begin
        // Dual-channel parts keep a CT on the primary for this code.
        pri_sens = i_dual_channel ? `CSD_SENS_CT : `CSD_SENS_SHUNT;
        pri_gain = i_dual_channel ? `CSD_GAIN_8 : `CSD_GAIN_32;
      end
    endcase
    // The secondary matches the primary except for the last code.
    if (cfg_sens == 2'h3) begin
      sec_sens = `CSD_SENS_SHUNT;
      sec_gain = `CSD_GAIN_32;
    end else begin
      sec_sens = pri_sens;
      sec_gain = pri_gain;
    end
  end

  // Configuration outputs, registered so every output is a flop.
  // Gains follow the gain and channel inputs one cycle late.
  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      o_test_lock         <= 1'b0;
      o_test_enable       <= 1'b0;
      o_clock_range_sel   <= 1'b0;
      o_sensor_type_sel   <= 2'h0;
      o_primary_sensor    <= `CSD_SENS_COIL;
      o_primary_gain      <= `CSD_GAIN_8;
      o_secondary_sensor  <= `CSD_SENS_COIL;
      o_secondary_gain    <= `CSD_GAIN_8;
      o_motor_divide_code <= 2'h0;
    end else begin
      o_test_lock         <= fuse_lock;
      // A zero in the lock bit keeps test mode open.
      o_test_enable       <= ~cfg_test;
      o_clock_range_sel   <= cfg_clk;
      o_sensor_type_sel   <= cfg_sens;
      o_primary_sensor    <= pri_sens;
      o_primary_gain      <= pri_gain;
      o_secondary_sensor  <= sec_sens;
      o_secondary_gain    <= sec_gain;
      o_motor_divide_code <= cfg_motor;
    end
  end

  // Rising edge of the energy pulse train; one count per pulse.
  // The previous level resets low like the idle input,
  // so no false edge is counted as reset ends.
  reg  pulse_prev_reg;                     // Previous input level.
  wire pulse_rise = i_active_energy_pulse & ~pulse_prev_reg;

  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      pulse_prev_reg <= 1'b0;
    end else begin
      pulse_prev_reg <= i_active_energy_pulse;
    end
  end

  // Motor divider: fires one step every divisor pulses.
  // A code change mid-count is not rescaled; one step may come early.
  reg  [11:0]   mot_cnt_reg;               // Pulses counted.
  wire [11:0]   mot_div = csd_divisor(i_voltage_scale_sel, cfg_motor);
  // Using >= keeps a shrunken divisor from running the counter past it.
  wire          mot_step = pulse_rise && (mot_cnt_reg >= mot_div - 12'h001);
  reg  [MW-1:0] mot_mono_reg;              // Cycles left in step pulse.
  reg           phase_a_reg;               // Phase A drive.
  reg           phase_b_reg;               // Phase B drive.
  reg           phase_sel_reg;             // Next phase to drive.

  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      mot_cnt_reg <= 12'h000;
    end else if (pulse_rise) begin
      mot_cnt_reg <= mot_step ? 12'h000 : mot_cnt_reg + 12'h001;
    end
  end

  // One-shot and decoder. A step arriving during a pulse restarts the
  // timer on the other phase; at real rates this never happens.
  // The width is taken from the scale bit at the step itself.
  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      mot_mono_reg  <= {MW{1'b0}};
      phase_a_reg   <= 1'b0;
      phase_b_reg   <= 1'b0;
      phase_sel_reg <= 1'b0;
    end else if (mot_step) begin
      mot_mono_reg  <= i_voltage_scale_sel ? STEP_LONG_CYC : STEP_SHORT_CYC;
      phase_a_reg   <= ~phase_sel_reg;
      phase_b_reg   <= phase_sel_reg;
      phase_sel_reg <= ~phase_sel_reg;
    end else if (mot_mono_reg != {MW{1'b0}}) begin
      // Counting down; the phases drop as the count reaches zero.
      mot_mono_reg <= mot_mono_reg - {{(MW-1){1'b0}}, 1'b1};
      if (mot_mono_reg == {{(MW-1){1'b0}}, 1'b1}) begin
        phase_a_reg <= 1'b0;
        phase_b_reg <= 1'b0;
      end
    end
  end

  // Pin drive: no-load wins over the sign, which inverts both phases.
  // This flop costs one cycle but keeps the pins glitch free.
  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      o_motor_out_pos <= 1'b0;
      o_motor_out_neg <= 1'b0;
    end else if (i_no_load) begin
      o_motor_out_pos <= 1'b0;
      o_motor_out_neg <= 1'b0;
    end else begin
      o_motor_out_pos <= phase_a_reg ^ i_energy_negative;
      o_motor_out_neg <= phase_b_reg ^ i_energy_negative;
    end
  end

  // Indicator divider, always on the low scale.
  // It runs beside the motor divider on the same edges.
  reg  [11:0]   ind_cnt_reg;               // Pulses counted.
  wire [11:0]   ind_div = csd_divisor(1'b0, cfg_motor);
  wire          ind_step = pulse_rise && (ind_cnt_reg >= ind_div - 12'h001);
  reg  [MW-1:0] ind_mono_reg;              // Cycles left in pulse.

  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      ind_cnt_reg <= 12'h000;
    end else if (pulse_rise) begin
      ind_cnt_reg <= ind_step ? 12'h000 : ind_cnt_reg + 12'h001;
    end
  end

  // Fixed-width pulse for the divided indicator.
  // A new step reloads the full width.
  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      ind_mono_reg <= {MW{1'b0}};
    end else if (ind_step) begin
      ind_mono_reg <= STEP_SHORT_CYC;
    end else if (ind_mono_reg != {MW{1'b0}}) begin
      ind_mono_reg <= ind_mono_reg - {{(MW-1){1'b0}}, 1'b1};
    end
  end

  // Undivided mode passes the pulse train straight through, one flop late.
  // A mode change mid-pulse may cut one indicator pulse short.
  always @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      o_indicator <= 1'b0;
    end else if (cfg_ind) begin
      o_indicator <= (ind_step || ind_mono_reg > {{(MW-1){1'b0}}, 1'b1});
    end else begin
      o_indicator <= i_active_energy_pulse;
    end
  end

endmodule

// *** sim/csd_checker.sv ***
// Assertions for the configuration store and stepper drive top level.
// Bound to csd_top; sees only its ports, all in the one clock domain.
`timescale 1ns/1ps

module csd_checker #(
  parameter [21:0] STEP_SHORT_CYC = 22'h000014,
  parameter [21:0] STEP_LONG_CYC  = 22'h000032
) (
  input wire logic       i_clock,           // System clock.
  input wire logic       i_rst_b,           // Reset, active low.
  input wire logic       i_cmd_valid,       // Command strobe.
  input wire logic       i_energy_negative, // Energy sign.
  input wire logic       i_no_load,         // No-load flag.
  input wire logic       i_dual_channel,    // Two-channel variant.
  input wire logic       o_motor_out_pos,   // Motor pin, positive.
  input wire logic       o_motor_out_neg,   // Motor pin, negative.
  input wire logic       o_cmd_done,        // Accept pulse.
  input wire logic       o_cmd_reject,      // Refuse pulse.
  input wire logic       o_test_lock,       // Permanent lock.
  input wire logic       o_test_enable,     // Test permit.
  input wire logic [1:0] o_sensor_type_sel, // Sensor field.
  input wire logic [1:0] o_primary_sensor,  // Primary kind.
  input wire logic [5:0] o_primary_gain     // Primary gain.
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  reg [21:0] run_reg; // Consecutive high samples of the positive pin.

  // Measure each pulse so that its end can be held against the one-shot widths.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b)
      run_reg <= 22'h000000;
    else if (o_motor_out_pos)
      run_reg <= run_reg + 22'h000001;
    else
      run_reg <= 22'h000000;
  end

  // Sign and load held quiet long enough that the pins are not being forced.
  sequence s_quiet;
    (!i_no_load && !i_energy_negative)[*3];
  endsequence
  // A pulse on the positive pin ends without the other phase taking over.
  sequence s_pos_end;
    $fell(o_motor_out_pos) ##0 !o_motor_out_neg;
  endsequence

  property p_width;
    s_quiet ##0 s_pos_end |-> run_reg == STEP_SHORT_CYC || run_reg == STEP_LONG_CYC;
  endproperty
  property p_answer_cause;
    o_cmd_done || o_cmd_reject |-> $past(i_cmd_valid);
  endproperty
  property p_one_answer;
    !(o_cmd_done && o_cmd_reject);
  endproperty
  property p_lock_refuse;
    i_cmd_valid && o_test_lock |=> o_cmd_reject && !o_cmd_done;
  endproperty
  property p_no_load;
    i_no_load |=> !o_motor_out_pos && !o_motor_out_neg;
  endproperty
  property p_lock_mode;
    o_test_lock && $past(o_test_lock, 3) |-> !o_test_enable;
  endproperty
  property p_pos_excl;
    (!i_energy_negative)[*2] |-> !(o_motor_out_pos && o_motor_out_neg);
  endproperty
  property p_neg_excl;
    (i_energy_negative && !i_no_load)[*3] |-> o_motor_out_pos || o_motor_out_neg;
  endproperty
  property p_ct;
    o_sensor_type_sel == 2'h2 && $stable(o_sensor_type_sel)
      |-> o_primary_sensor == 2'h1 && o_primary_gain == 6'h08;
  endproperty
  property p_shunt;
    o_sensor_type_sel == 2'h3 && $stable(o_sensor_type_sel) && !$past(i_dual_channel)
      |-> o_primary_sensor == 2'h2 && o_primary_gain == 6'h20;
  endproperty

  a_width: assert property (p_width) else $error("motor pulse width wrong");
  a_answer_cause: assert property (p_answer_cause) else $error("answer without command");
  a_one_answer: assert property (p_one_answer) else $error("accept and refuse together");
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked command taken");
  a_no_load: assert property (p_no_load) else $error("pins not low on no load");
  a_lock_mode: assert property (p_lock_mode) else $error("test permitted when locked");
  a_pos_excl: assert property (p_pos_excl) else $error("both phases high");
  a_neg_excl: assert property (p_neg_excl) else $error("pins not inverted");
  a_ct: assert property (p_ct) else $error("sensor code two decode wrong");
  a_shunt: assert property (p_shunt) else $error("sensor code three decode wrong");
endmodule

// *** sim/csd_prog.sv ***
// Model of the external programmer on the configuration command port.
// Assumes the block answers on the same edge that takes a byte.
`timescale 1ns/1ps

module csd_prog (
  input  wire logic       i_clock,      // System clock.
  input  wire logic       i_cmd_done,   // Accept pulse from the block.
  input  wire logic       i_cmd_reject, // Refuse pulse from the block.
  output logic            o_cmd_valid,  // Byte strobe.
  output logic      [7:0] o_cmd_byte    // Command byte.
);
  logic [1:0] result; // Refuse and accept flags seen for the last byte.

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_byte  = 8'hFF;
    result      = 2'h0;
  end

  // One byte carries value, fuse flag and bit address for a single cell.
  // The answer stands one cycle only, so it is sampled mid-cycle after the taking edge.
  task automatic send(input logic [7:0] b);
    @(negedge i_clock);
    o_cmd_valid = 1'b1;
    o_cmd_byte  = b;
    @(negedge i_clock);
    result      = {i_cmd_reject, i_cmd_done};
    o_cmd_valid = 1'b0;
    // A released byte must not look like the last one, so it is inverted.
    o_cmd_byte  = ~b;
  endtask
endmodule

// *** sim/csd_top_tb.sv ***
// Self-checking bench for the configuration store and stepper drive.
// Assumes the design under src/ and the programmer model in sim/.
`timescale 1ns/1ps
`include "csd_consts.vh"

module csd_top_tb;
  localparam [21:0] SH = 22'h000014; // Short one-shot, shortened for run time.
  localparam [21:0] LG = 22'h000032; // Long one-shot, shortened for run time.

  logic       clock = 1'b0;     // 20 MHz clock.
  logic       rst_b = 1'b0;     // Reset, active low.
  logic       blank_b = 1'b0;   // Fresh-part fuse clear, active low.
  logic       rd_shadow = 1'b0; // Read source select.
  logic       aep = 1'b0;       // Energy pulse train.
  logic       neg = 1'b0;       // Energy sign.
  logic       nold = 1'b0;      // No-load flag.
  logic       scale = 1'b0;     // Voltage scale.
  logic       side = 1'b0;      // Phase expected for the next step.
  logic       xg = 1'b0;        // Extra gain enable.
  logic       dual = 1'b0;      // Two-channel part.
  int         len = 0;          // Measured pulse length.
  wire        cmd_valid;
  wire  [7:0] cmd_byte;
  wire        pos, mneg, ind, done, rej, lock, ten, crs;
  wire  [1:0] sts, psen, ssen, mdc;
  wire  [5:0] pgain, sgain;
  int         bad_count = 0;
  int         total_checks = 0;
  // Rows: command byte, then expected clock range, sensor field and divide code.
  logic [12:0] rows [6] = '{13'h1030, 13'h10B4, 13'h10DC, 13'h11FE, 13'h00BA, 13'h002A};
  int          divs [4] = '{`CSD_DIV_0, `CSD_DIV_1, `CSD_DIV_2, `CSD_DIV_3};

  always #25 clock = ~clock;

  csd_prog prog (.i_clock(clock), .i_cmd_done(done), .i_cmd_reject(rej),
                 .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte));

  csd_top #(.STEP_SHORT_CYC(SH), .STEP_LONG_CYC(LG)) dut (
    .i_clock(clock), .i_rst_b(rst_b), .i_fuse_blank_b(blank_b),
    .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte), .i_read_shadow(rd_shadow),
    .i_active_energy_pulse(aep), .i_energy_negative(neg), .i_no_load(nold),
    .i_voltage_scale_sel(scale), .i_extra_gain_en(xg), .i_dual_channel(dual),
    .o_motor_out_pos(pos), .o_motor_out_neg(mneg), .o_indicator(ind),
    .o_cmd_done(done), .o_cmd_reject(rej), .o_test_lock(lock), .o_test_enable(ten),
    .o_clock_range_sel(crs), .o_sensor_type_sel(sts), .o_primary_sensor(psen),
    .o_primary_gain(pgain), .o_secondary_sensor(ssen), .o_secondary_gain(sgain),
    .o_motor_divide_code(mdc));

  // Print the counts and the verdict, then stop.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compare with four-state equality so an unknown never matches.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Reset, then wait until the two-flop release and the word pipeline settle.
  task automatic do_reset;
    rst_b = 1'b0;
    ticks(12);
    rst_b = 1'b1;
    ticks(8);
  endtask

  // Send a byte, check the answer, and let the outputs catch up.
  task automatic cmd(input logic [7:0] b, input logic [1:0] exp);
    prog.send(b);
    check("cmd_answer", prog.result, exp);
    ticks(4);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clock);
      aep = 1'b1;
      @(negedge clock);
      aep = 1'b0;
    end
  endtask

  // Count the negedges for which a pin stays high; a stuck pin ends the run.
  task automatic high_time(input int sel, output int n);
    n = 0;
    while (n < 4000 && (sel == 2 ? ind : sel ? mneg : pos) === 1'b1) begin
      @(negedge clock);
      n++;
    end
    if (n == 4000) begin
      bad_count++;
      end_sim();
    end
  endtask

  // Sensor decode of both channels, once any input change has settled.
  task automatic sens(input logic [15:0] e);
    ticks(2);
    check("sensor", {psen, pgain, ssen, sgain}, e);
  endtask

  // Feed one division's worth of pulses and measure the resulting step.
  task automatic step(input int n, input logic [21:0] w, input logic b_side);
    int k;
    pulses(n - 1);
    check("pins_idle", {pos, mneg}, 2'h0);
    pulses(1);
    k = 0;
    while (k < 4 && (b_side ? mneg : pos) !== 1'b1) begin
      @(negedge clock);
      k++;
    end
    if (k == 4) begin
      bad_count++;
      end_sim();
    end
    check("other_phase", b_side ? pos : mneg, 1'b0);
    high_time(b_side, k);
    check("step_width", k, w);
  endtask

  initial begin
    ticks(2);
    blank_b = 1'b1;
    ticks(10);
    check("reset_outputs", {pos, mneg, ind, done, rej, lock, ten, crs, sts, mdc, pgain},
          {12'h000, 6'h08});
    rst_b = 1'b1;
    ticks(8);
    check("blank_fuses", {lock, ten, crs, sts, mdc}, 7'h20);
    $display("test reset done");
    rd_shadow = 1'b1;
    for (int i = 0; i < 6; i++) begin
      cmd(rows[i][12:5], 2'h1);
      check("cfg_word", {crs, sts, mdc}, rows[i][4:0]);
    end
    $display("test table done");
    sens(16'h4848);
    cmd(8'h85, 2'h1);
    sens(16'hA0A0);
    dual = 1'b1;
    sens(16'h48A0);
    dual = 1'b0;
    cmd(8'h06, 2'h1);
    sens(16'h1818);
    xg = 1'b1;
    sens(16'h2020);
    cmd(8'h05, 2'h1);
    sens(16'h1010);
    xg = 1'b0;
    sens(16'h0808);
    $display("test sensor done");
    for (int c = 0; c < 4; c++) begin
      cmd({c[0], 7'h0E}, 2'h1);
      cmd({c[1], 7'h0F}, 2'h1);
      for (int s = 0; s < 2; s++) begin
        scale = s[0];
        step(divs[c] * (s ? `CSD_DIV_SCALE : 1), s ? LG : SH, side);
        side = ~side;
      end
    end
    @(negedge clock);
    aep = 1'b1;
    @(negedge clock);
    check("indicator_follow", ind, 1'b1);
    aep = 1'b0;
    $display("test motor done");
    neg = 1'b1;
    ticks(3);
    check("neg_idle", {pos, mneg}, 2'h3);
    nold = 1'b1;
    ticks(2);
    check("no_load", {pos, mneg}, 2'h0);
    nold = 1'b0;
    neg = 1'b0;
    ticks(3);
    $display("test sign done");
    cmd(8'h81, 2'h1);
    do_reset();
    check("shadow_clear", crs, 1'b0);
    cmd(8'h83, 2'h1);
    pulses(divs[0] - 1);
    check("ind_idle", ind, 1'b0);
    pulses(1);
    high_time(2, len);
    check("ind_width", len, SH);
    rd_shadow = 1'b0;
    cmd(8'h41, 2'h1);
    check("fuse_zero_write", crs, 1'b0);
    cmd(8'hC1, 2'h1);
    check("fuse_set", crs, 1'b1);
    rd_shadow = 1'b1;
    ticks(4);
    check("shadow_view", crs, 1'b0);
    cmd(8'hC0, 2'h1);
    check("locked", {lock, ten}, 2'h2);
    cmd(8'h81, 2'h2);
    check("fuse_forced", crs, 1'b1);
    $display("test lock done");
    end_sim();
  end
endmodule

bind csd_top csd_checker #(
  .STEP_SHORT_CYC(STEP_SHORT_CYC),
  .STEP_LONG_CYC (STEP_LONG_CYC)
) u_checker (
  .i_clock          (i_clock),
  .i_rst_b          (i_rst_b),
  .i_cmd_valid      (i_cmd_valid),
  .i_energy_negative(i_energy_negative),
  .i_no_load        (i_no_load),
  .i_dual_channel   (i_dual_channel),
  .o_motor_out_pos  (o_motor_out_pos),
  .o_motor_out_neg  (o_motor_out_neg),
  .o_cmd_done       (o_cmd_done),
  .o_cmd_reject     (o_cmd_reject),
  .o_test_lock      (o_test_lock),
  .o_test_enable    (o_test_enable),
  .o_sensor_type_sel(o_sensor_type_sel),
  .o_primary_sensor (o_primary_sensor),
  .o_primary_gain   (o_primary_gain)
);
